// ### hw/pev_top.sv
// exception vectoring with prioritised peripheral interrupt controller
// Function
// - on a taken event pulse take_o with the source's fixed vector
// - handlers always run with the supervisor flag set
// - bus error from an invalid or disabled target vectors to 0x08
// - tick timer interrupt vectors to 0x0E
// - misaligned 16-bit or 32-bit access vectors to 0x14
// - unrecognised instruction fetch vectors to 0x1A
// - system call instruction vectors to 0x26
// - software trap or debug unit request vectors to 0x2C
// - hardware or software reset vectors to 0x38
// - enabled stack check reaching the limit vectors to 0x3E
// - peripheral and pin requests are individually masked, delivered at 0x20
// - each source has priority 0 to 15, zero never interrupts
// - several sources may share one priority level
// - equal or lower priority events do not interrupt a running handler
// - strictly higher priority events pre-empt the running handler
// - completing a handler lets lower pending levels be serviced
// - pin and selected peripheral requests wake the device from sleep
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
module pev_top #(
   parameter int NP = 8,
   parameter int ND = 4
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // apb slave
   input  wire logic [11:0]       paddr_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // core events
   input  wire logic              mem_req_i,
   input  wire logic [1:0]        mem_size_i,
   input  wire logic [1:0]        mem_addr_i,
   input  wire logic              bus_err_i,
   input  wire logic              illegal_i,
   input  wire logic              syscall_i,
   input  wire logic              trap_i,
   input  wire logic              debug_trap_i,
   input  wire logic              sw_reset_i,
   input  wire logic              tick_i,
   input  wire logic [31:0]       sp_i,
   input  wire logic              ret_i,
   // core vectoring
   output logic                   take_o,
   output logic      [7:0]        vector_o,
   output logic                   sup_o,
   output logic                   hw_irq_o,
   // interrupt sources and sleep
   input  wire logic [NP-1:0]     src_irq_i,
   input  wire logic [ND-1:0]     dio_i,
   input  wire logic              sleep_i,
   output logic                   wake_o,
   output logic                   irq_o
);
   localparam int NS = NP + ND;
   localparam int IW = (NS > 1) ? $clog2(NS) : 1;
   localparam int PW = (NS + 7) / 8;
   localparam int EV_W = pev_pkg::EV_N;

   pev_pkg::pev_state_type state_q;
   logic [ND-1:0]     dio_s1_q;
   logic [ND-1:0]     dio_s2_q;
   logic [NS-1:0]     src;
   logic [NS-1:0]     pend;
   logic [3:0]        prio_q [NS];
   logic [NS-1:0]     mask_q;
   logic [NP-1:0]     wake_en_q;
   logic              stk_en_q;
   logic [31:0]       slim_q;
   logic              stk_q;
   logic              stk_hit;
   logic [15:0]       act_q;
   logic [IW-1:0]     claim_q;
   logic [IW-1:0]     best_idx;
   logic [3:0]        best_lvl;
   logic [3:0]        curr_lvl;
   logic              hw_req;
   logic [EV_W-1:0]   ev;
   logic [3:0]        win;
   logic [EV_W-1:0]   stat_q;
   logic [EV_W-1:0]   ien_q;
   logic              take_q;
   logic [7:0]        vec_q;
   logic              sup_q;
   logic              saved_q;
   logic              wr;
   logic              hw_take;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a[11:2] == off[11:2]);
   endfunction

   function automatic logic [7:0] vec_of(input logic [3:0] i);
      case (i)
         4'h0:    vec_of = pev_pkg::VEC_RESET;
         4'h1:    vec_of = pev_pkg::VEC_BUSERR;
         4'h2:    vec_of = pev_pkg::VEC_ALIGN;
         4'h3:    vec_of = pev_pkg::VEC_ILLEG;
         4'h4:    vec_of = pev_pkg::VEC_STACK;
         4'h5:    vec_of = pev_pkg::VEC_TRAP;
         4'h6:    vec_of = pev_pkg::VEC_SYSC;
         4'h7:    vec_of = pev_pkg::VEC_TICK;
         default: vec_of = pev_pkg::VEC_HWIRQ;
      endcase
   endfunction

   function automatic logic [3:0] hi_lvl(input logic [15:0] m);
      hi_lvl = 4'h0;
      for (int i = 1; i < 16; i++)
      begin
         if (m[i])
            hi_lvl = 4'(i);
      end
   endfunction

   // pin requests cross into the clock domain
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         dio_s1_q <= '0;
         dio_s2_q <= '0;
      end
      else
      begin
         dio_s1_q <= dio_i;
         dio_s2_q <= dio_s1_q;
      end
   end

   assign src = {dio_s2_q, src_irq_i};
   assign wr  = psel_i & penable_i & pwrite_i;

   // masked, nonzero-priority requests
   always_comb
   begin
      for (int i = 0; i < NS; i++)
         pend[i] = src[i] & mask_q[i] & (prio_q[i] != 4'h0);
   end

   // highest level wins, lowest index among equals
   always_comb
   begin
      best_lvl = 4'h0;
      best_idx = '0;
      for (int i = NS - 1; i >= 0; i--)
      begin
         if (pend[i] && prio_q[i] >= best_lvl)
         begin
            best_lvl = prio_q[i];
            best_idx = IW'(i);
         end
      end
   end

   assign curr_lvl = hi_lvl(act_q);
   // pre-empt only above the level in service
   assign hw_req   = !sleep_i && (best_lvl > curr_lvl);
   assign hw_irq_o = hw_req;

   // stack limit reached, one event per crossing
   assign stk_hit = stk_en_q && (sp_i <= slim_q);
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         stk_q <= 1'b0;
      else
         stk_q <= stk_hit;
   end

   always_comb
   begin
      ev = '0;
      ev[pev_pkg::EV_RESET] = (state_q == pev_pkg::PEV_BOOT) | sw_reset_i;
      ev[pev_pkg::EV_BUS]   = bus_err_i;
      ev[pev_pkg::EV_ALIGN] = mem_req_i &
         (((mem_size_i == pev_pkg::SZ_HALF) & mem_addr_i[0]) |
          ((mem_size_i == pev_pkg::SZ_WORD) & (mem_addr_i != 2'h0)));
      ev[pev_pkg::EV_ILLEG] = illegal_i;
      ev[pev_pkg::EV_STACK] = stk_hit & ~stk_q;
      ev[pev_pkg::EV_TRAP]  = trap_i | debug_trap_i;
      ev[pev_pkg::EV_SYSC]  = syscall_i;
      ev[pev_pkg::EV_TICK]  = tick_i;
      ev[pev_pkg::EV_HW]    = hw_req;
   end

   always_comb
   begin
      win = 4'h8;
      for (int i = EV_W - 1; i >= 0; i--)
      begin
         if (ev[i])
            win = 4'(i);
      end
   end

   assign hw_take = (|ev) && (win == 4'(pev_pkg::EV_HW));

   // boot issues the reset vector once
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         state_q <= pev_pkg::PEV_BOOT;
      else
      begin
         case (state_q)
            pev_pkg::PEV_BOOT: state_q <= pev_pkg::PEV_RUN;
            pev_pkg::PEV_RUN:  state_q <= pev_pkg::PEV_RUN;
            default:           state_q <= pev_pkg::PEV_BOOT;
         endcase
      end
   end

   // vector to the core
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         take_q <= 1'b0;
         vec_q  <= pev_pkg::VEC_RESET;
      end
      else
      begin
         take_q <= |ev;
         if (|ev)
            vec_q <= vec_of(win);
      end
   end
   assign take_o   = take_q;
   assign vector_o = vec_q;

   // supervisor flag with one saved level
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         sup_q   <= 1'b1;
         saved_q <= 1'b1;
      end
      else if (|ev)
      begin
         sup_q   <= 1'b1;
         saved_q <= sup_q;
      end
      else if (ret_i)
         sup_q <= saved_q;
   end
   assign sup_o = sup_q;

   // levels in service, cleared on handler completion
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || sw_reset_i)
      begin
         act_q   <= 16'h0000;
         claim_q <= '0;
      end
      else
      begin
         act_q <= (act_q & ~((wr && hit(paddr_i, pev_pkg::OFF_DONE)) ?
                  (16'h0001 << curr_lvl) : 16'h0000)) |
                  (hw_take ? (16'h0001 << best_lvl) : 16'h0000);
         if (hw_take)
            claim_q <= best_idx;
      end
   end

   // sticky event status, set wins over clear
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         stat_q <= '0;
      else
         stat_q <= (stat_q & ~((wr && hit(paddr_i, pev_pkg::OFF_CLR)) ?
                   pwdata_i[EV_W-1:0] : '0)) | ev;
   end
   assign irq_o = |(stat_q & ien_q);

   // software registers
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         stk_en_q  <= 1'b0;
         slim_q    <= pev_pkg::RST_SLIM;
         mask_q    <= '0;
         ien_q     <= '0;
         wake_en_q <= '0;
         for (int i = 0; i < NS; i++)
            prio_q[i] <= pev_pkg::RST_PRIO;
      end
      else if (wr)
      begin
         if (hit(paddr_i, pev_pkg::OFF_CTRL))
            stk_en_q <= pwdata_i[0];
         else if (hit(paddr_i, pev_pkg::OFF_SLIM))
            slim_q <= pwdata_i;
         else if (hit(paddr_i, pev_pkg::OFF_MASK))
            mask_q <= pwdata_i[NS-1:0];
         else if (hit(paddr_i, pev_pkg::OFF_IEN))
            ien_q <= pwdata_i[EV_W-1:0];
         else if (hit(paddr_i, pev_pkg::OFF_WAKE))
            wake_en_q <= pwdata_i[NP-1:0];
         for (int i = 0; i < NS; i++)
         begin
            if (hit(paddr_i, pev_pkg::OFF_PRIO + 12'(4 * (i / 8))))
               prio_q[i] <= pwdata_i[4*(i%8) +: 4];
         end
      end
   end

   // read mux and unmapped detection
   logic        mapped;
   logic [31:0] rd;
   always_comb
   begin
      mapped = 1'b1;
      rd     = 32'h0000_0000;
      if (hit(paddr_i, pev_pkg::OFF_CTRL))
         rd[0] = stk_en_q;
      else if (hit(paddr_i, pev_pkg::OFF_SLIM))
         rd = slim_q;
      else if (hit(paddr_i, pev_pkg::OFF_MASK))
         rd[NS-1:0] = mask_q;
      else if (hit(paddr_i, pev_pkg::OFF_DONE) || hit(paddr_i, pev_pkg::OFF_CLR))
         rd = 32'h0000_0000;
      else if (hit(paddr_i, pev_pkg::OFF_STATE))
      begin
         rd[pev_pkg::ST_CUR_POS +: 4]  = curr_lvl;
         rd[pev_pkg::ST_BEST_POS +: 4] = best_lvl;
         rd[pev_pkg::ST_CLM_POS +: IW] = claim_q;
         rd[pev_pkg::ST_ACT_POS +: 16] = act_q;
      end
      else if (hit(paddr_i, pev_pkg::OFF_STAT))
         rd[EV_W-1:0] = stat_q;
      else if (hit(paddr_i, pev_pkg::OFF_IEN))
         rd[EV_W-1:0] = ien_q;
      else if (hit(paddr_i, pev_pkg::OFF_WAKE))
         rd[NP-1:0] = wake_en_q;
      else if (paddr_i >= pev_pkg::OFF_PRIO &&
               paddr_i < pev_pkg::OFF_PRIO + 12'(4 * PW))
      begin
         for (int i = 0; i < NS; i++)
         begin
            if (hit(paddr_i, pev_pkg::OFF_PRIO + 12'(4 * (i / 8))))
               rd[4*(i%8) +: 4] = prio_q[i];
         end
      end
      else
         mapped = 1'b0;
   end
   assign prdata_o  = rd;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped;

   // always-on wake path, controller is off in sleep
   assign wake_o = sleep_i & ((|dio_s2_q) | (|(src_irq_i & wake_en_q)));

   property p_reset_vec;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |=> take_o && vector_o == pev_pkg::VEC_RESET;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("no reset vector");

   property p_sup;
      @(posedge clk_i) disable iff (!rst_n_i)
      take_o |-> sup_o;
   endproperty
   a_sup: assert property (p_sup) else $error("handler not supervisor");

   property p_bus;
      @(posedge clk_i) disable iff (!rst_n_i)
      bus_err_i && !ev[pev_pkg::EV_RESET] |=> take_o && vector_o == 8'h08;
   endproperty
   a_bus: assert property (p_bus) else $error("bus error vector wrong");

   property p_align;
      @(posedge clk_i) disable iff (!rst_n_i)
      mem_req_i && mem_size_i == 2'h2 && mem_addr_i == 2'h2 && !(|ev[1:0])
      |=> take_o && vector_o == 8'h14;
   endproperty
   a_align: assert property (p_align) else $error("alignment vector wrong");

   property p_tick;
      @(posedge clk_i) disable iff (!rst_n_i)
      tick_i && ev[6:0] == 7'h00 |=> take_o && vector_o == 8'h0E;
   endproperty
   a_tick: assert property (p_tick) else $error("tick vector wrong");

   property p_sysc;
      @(posedge clk_i) disable iff (!rst_n_i)
      syscall_i |=> stat_q[pev_pkg::EV_SYSC] && sup_o;
   endproperty
   a_sysc: assert property (p_sysc) else $error("syscall not seen");

   property p_noprem;
      @(posedge clk_i) disable iff (!rst_n_i)
      hw_take |=> !hw_irq_o || best_lvl > $past(best_lvl);
   endproperty
   a_noprem: assert property (p_noprem) else $error("same level re-raised");

   property p_prem;
      @(posedge clk_i) disable iff (!rst_n_i)
      hw_take |=> curr_lvl == $past(best_lvl) && claim_q == $past(best_idx);
   endproperty
   a_prem: assert property (p_prem) else $error("level not entered");

   property p_done;
      @(posedge clk_i) disable iff (!rst_n_i)
      wr && hit(paddr_i, pev_pkg::OFF_DONE) && curr_lvl != 4'h0 && !hw_take
      |=> curr_lvl < $past(curr_lvl);
   endproperty
   a_done: assert property (p_done) else $error("completion ignored");

   property p_mask;
      @(posedge clk_i) disable iff (!rst_n_i)
      hw_irq_o |-> mask_q[best_idx] && prio_q[best_idx] != 4'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("masked source raised");

   property p_wake;
      @(posedge clk_i) disable iff (!rst_n_i)
      sleep_i && (|dio_s2_q) |-> wake_o && !hw_irq_o;
   endproperty
   a_wake: assert property (p_wake) else $error("pin did not wake");

   c_hw: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      hw_take ##1 hw_take);
   c_done: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      hw_take ##[1:20] (wr && hit(paddr_i, pev_pkg::OFF_DONE)));
   c_stack: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      ev[pev_pkg::EV_STACK]);
endmodule // pev_top

// ### hw/pev_pkg.sv
// constants for the exception vectoring and priority interrupt controller
package pev_pkg;
   // fixed handler addresses
   localparam logic [7:0] VEC_BUSERR = 8'h08;
   localparam logic [7:0] VEC_TICK   = 8'h0E;
   localparam logic [7:0] VEC_ALIGN  = 8'h14;
   localparam logic [7:0] VEC_ILLEG  = 8'h1A;
   localparam logic [7:0] VEC_HWIRQ  = 8'h20;
   localparam logic [7:0] VEC_SYSC   = 8'h26;
   localparam logic [7:0] VEC_TRAP   = 8'h2C;
   localparam logic [7:0] VEC_RESET  = 8'h38;
   localparam logic [7:0] VEC_STACK  = 8'h3E;
   // event index, lowest index wins arbitration
   localparam int EV_RESET = 0;
   localparam int EV_BUS   = 1;
   localparam int EV_ALIGN = 2;
   localparam int EV_ILLEG = 3;
   localparam int EV_STACK = 4;
   localparam int EV_TRAP  = 5;
   localparam int EV_SYSC  = 6;
   localparam int EV_TICK  = 7;
   localparam int EV_HW    = 8;
   localparam int EV_N     = 9;
   // register byte offsets
   localparam logic [11:0] OFF_CTRL  = 12'h000;
   localparam logic [11:0] OFF_SLIM  = 12'h004;
   localparam logic [11:0] OFF_MASK  = 12'h008;
   localparam logic [11:0] OFF_DONE  = 12'h00C;
   localparam logic [11:0] OFF_STATE = 12'h010;
   localparam logic [11:0] OFF_STAT  = 12'h014;
   localparam logic [11:0] OFF_CLR   = 12'h018;
   localparam logic [11:0] OFF_IEN   = 12'h01C;
   localparam logic [11:0] OFF_WAKE  = 12'h020;
   localparam logic [11:0] OFF_PRIO  = 12'h040;
   // state register fields
   localparam int ST_CUR_POS  = 0;
   localparam int ST_BEST_POS = 4;
   localparam int ST_CLM_POS  = 8;
   localparam int ST_ACT_POS  = 16;
   // access sizes
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   // values after reset
   localparam logic [31:0] RST_SLIM = 32'h0000_0000;
   localparam logic [3:0]  RST_PRIO = 4'h0;
   typedef enum logic [1:0] {
      PEV_BOOT = 2'b01,
      PEV_RUN  = 2'b10
   } pev_state_type;
endpackage

// ### tb/pev_core_model.sv
// core side model: event pulses, data accesses, stack pointer, pc capture
`timescale 1ns/100ps
module pev_core_model (
   // clock
   input  wire logic        clk_i,
   // vectoring from the controller
   input  wire logic        take_i,
   input  wire logic [7:0]  vector_i,
   // bus, illegal, syscall, trap, debug, sw reset, tick, return
   output logic      [7:0]  ev_o,
   // data access and stack pointer
   output logic             mem_req_o,
   output logic      [1:0]  mem_size_o,
   output logic      [1:0]  mem_addr_o,
   output logic      [31:0] sp_o
);
   logic [7:0] pc_q;

   initial
   begin
      ev_o = 8'h00;
      mem_req_o = 1'b0;
      mem_size_o = 2'h0;
      mem_addr_o = 2'h0;
      sp_o = 32'h0000_1000;
      pc_q = 8'h00;
   end

   // core jumps to the vector on each take
   always @(posedge clk_i)
   begin
      if (take_i)
      begin
         pc_q <= vector_i;
      end
   end

   task automatic pulse(input int b);
      @(posedge clk_i);
      ev_o <= 8'h01 << b;
      @(posedge clk_i);
      ev_o <= 8'h00;
   endtask

   task automatic access(input logic [1:0] sz, input logic [1:0] a);
      @(posedge clk_i);
      mem_req_o <= 1'b1;
      mem_size_o <= sz;
      mem_addr_o <= a;
      @(posedge clk_i);
      mem_req_o <= 1'b0;
      mem_size_o <= ~sz;
      mem_addr_o <= ~a;
   endtask

   task automatic set_sp(input logic [31:0] v);
      @(posedge clk_i);
      sp_o <= v;
   endtask
endmodule // pev_core_model

// ### tb/priority_exception_vectoring_bench.sv
// self-checking bench for the exception vectoring and interrupt controller
`timescale 1ns/100ps
`define CHK(a, b) \
   begin \
      tests_run++; \
      if ((a) !== (b)) \
      begin \
         n_mismatch++; \
         $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); \
      end \
   end
module priority_exception_vectoring_bench;
   logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i, sleep_i, rerr;
   logic        pready_o, pslverr_o, take_o, sup_o, hw_irq_o, wake_o, irq_o, mreq;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, sp, rdat;
   logic [7:0]  ev, vector_o, src_irq_i;
   logic [1:0]  msz, madr;
   logic [3:0]  dio_i;
   int          n_mismatch, tests_run, cycles;
   logic [7:0]  vecs [7] = '{pev_pkg::VEC_BUSERR, pev_pkg::VEC_ILLEG, pev_pkg::VEC_SYSC,
                            pev_pkg::VEC_TRAP, pev_pkg::VEC_TRAP, pev_pkg::VEC_RESET,
                            pev_pkg::VEC_TICK};

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   pev_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_req_i(mreq), .mem_size_i(msz),
      .mem_addr_i(madr), .bus_err_i(ev[0]), .illegal_i(ev[1]), .syscall_i(ev[2]),
      .trap_i(ev[3]), .debug_trap_i(ev[4]), .sw_reset_i(ev[5]), .tick_i(ev[6]),
      .sp_i(sp), .ret_i(ev[7]), .take_o(take_o), .vector_o(vector_o), .sup_o(sup_o),
      .hw_irq_o(hw_irq_o), .src_irq_i(src_irq_i), .dio_i(dio_i), .sleep_i(sleep_i),
      .wake_o(wake_o), .irq_o(irq_o));

   pev_core_model core (.clk_i(clk_i), .take_i(take_o), .vector_i(vector_o), .ev_o(ev),
      .mem_req_o(mreq), .mem_size_o(msz), .mem_addr_o(madr), .sp_o(sp));

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         results();
      end
   end

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      pwdata_i <= ~d;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rdat, exp)
   endtask

   // bounded wait for a take, then check vector, mode and core pc
   task automatic wait_take(input logic [7:0] exp);
      #1;
      for (int i = 0; i < 8 && take_o !== 1'b1; i++)
      begin
         @(posedge clk_i);
         #1;
      end
      `CHK(take_o, 1'b1)
      `CHK(vector_o, exp)
      `CHK(sup_o, 1'b1)
      @(posedge clk_i);
      #1;
      `CHK(core.pc_q, exp)
   endtask

   task automatic no_take(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         #1;
         `CHK(take_o, 1'b0)
      end
   endtask

   initial
   begin
      rst_n_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0000_0000;
      src_irq_i = 8'h00;
      dio_i = 4'h0;
      sleep_i = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      cycles = 0;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wait_take(pev_pkg::VEC_RESET);
      for (int k = 0; k < 7; k++)
      begin
         core.pulse(k);
         wait_take(vecs[k]);
      end
      core.pulse(7);
      no_take(3);
      `CHK(sup_o, 1'b1)
      core.access(pev_pkg::SZ_HALF, 2'h1);
      wait_take(pev_pkg::VEC_ALIGN);
      core.access(pev_pkg::SZ_WORD, 2'h2);
      wait_take(pev_pkg::VEC_ALIGN);
      core.access(pev_pkg::SZ_HALF, 2'h2);
      no_take(3);
      core.access(pev_pkg::SZ_WORD, 2'h0);
      no_take(3);
      wr(pev_pkg::OFF_SLIM, 32'h0000_0100);
      rd(pev_pkg::OFF_SLIM, 32'h0000_0100);
      core.set_sp(32'h0000_0100);
      no_take(3);
      core.set_sp(32'h0000_1000);
      wr(pev_pkg::OFF_CTRL, 32'h0000_0001);
      core.set_sp(32'h0000_0100);
      wait_take(pev_pkg::VEC_STACK);
      // sources 0,2,3,5 unmasked; levels 0,5,9,5; source 4 masked at 7
      wr(pev_pkg::OFF_MASK, 32'h0000_002D);
      wr(pev_pkg::OFF_PRIO, 32'h0057_9500);
      src_irq_i <= 8'h11;
      no_take(4);
      `CHK(hw_irq_o, 1'b0)
      src_irq_i <= 8'h35;
      wait_take(pev_pkg::VEC_HWIRQ);
      `CHK(hw_irq_o, 1'b0)
      apb(1'b0, pev_pkg::OFF_STATE, 32'h0000_0000);
      `CHK(rdat[11:8], 4'h2)
      `CHK(rdat[3:0], 4'h5)
      src_irq_i <= 8'h3D;
      wait_take(pev_pkg::VEC_HWIRQ);
      apb(1'b0, pev_pkg::OFF_STATE, 32'h0000_0000);
      `CHK(rdat[11:0], 12'h399)
      src_irq_i <= 8'h35;
      wr(pev_pkg::OFF_DONE, 32'h0000_0000);
      no_take(4);
      wr(pev_pkg::OFF_DONE, 32'h0000_0000);
      wait_take(pev_pkg::VEC_HWIRQ);
      src_irq_i <= 8'h00;
      wr(pev_pkg::OFF_DONE, 32'h0000_0000);
      rd(pev_pkg::OFF_STAT, 32'h0000_01FF);
      wr(pev_pkg::OFF_IEN, 32'h0000_0000);
      `CHK(irq_o, 1'b0)
      wr(pev_pkg::OFF_IEN, 32'h0000_0080);
      `CHK(irq_o, 1'b1)
      wr(pev_pkg::OFF_CLR, 32'h0000_0080);
      `CHK(irq_o, 1'b0)
      rd(pev_pkg::OFF_STAT, 32'h0000_017F);
      rd(12'h030, 32'h0000_0000);
      `CHK(rerr, 1'b1)
      src_irq_i <= 8'h04;
      sleep_i <= 1'b1;
      dio_i <= 4'h1;
      repeat (4) @(posedge clk_i);
      #1;
      `CHK(wake_o, 1'b1)
      `CHK(hw_irq_o, 1'b0)
      dio_i <= 4'h0;
      repeat (4) @(posedge clk_i);
      #1;
      `CHK(wake_o, 1'b0)
      wr(pev_pkg::OFF_WAKE, 32'h0000_0004);
      `CHK(wake_o, 1'b1)
      rd(pev_pkg::OFF_WAKE, 32'h0000_0004);
      results();
   end
endmodule // priority_exception_vectoring_bench
